// ==== irs_pkg.sv ====
// Shared constants of the core sequencer: opcodes, map limits, register port.
// Assumes a single 125 MHz core clock and a synchronous register port.
package irs_pkg;

  // ----------------------------------------
  // Instruction word layout
  // ----------------------------------------
  localparam int OPC_MSB = 9;
  localparam int OPC_LSB = 6;

  typedef enum logic [3:0] {
    OP_MISC  = 4'h0,
    OP_JMP   = 4'h1,
    OP_JC    = 4'h2,
    OP_JNC   = 4'h3,
    OP_JF    = 4'h4,
    OP_JNF   = 4'h5,
    OP_CALL  = 4'h6,
    OP_RET   = 4'h7,
    OP_ANL   = 4'h8,
    OP_XRL   = 4'h9,
    OP_ORL   = 4'ha,
    OP_ROT   = 4'hb,
    OP_INC   = 4'hc,
    OP_MOV   = 4'hd,
    OP_CONDITION_TEST_INSTRUCTION  = 4'he,
    OP_HALT  = 4'hf
  } irs_op_t;

  typedef enum logic [0:0] {
    ST_RUN     = 1'b0,
    ST_STANDBY = 1'b1
  } irs_state_t;

  // ----------------------------------------
  // Address map and reset values
  // ----------------------------------------
  localparam logic [9:0] RESET_IP  = 10'h000;
  localparam logic [9:0] TEST_BASE = 10'h3ea;
  localparam logic [4:0] R0_LO     = 5'h00;
  localparam logic [4:0] R0_HI     = 5'h10;
  localparam logic [4:0] RF_LO     = 5'h0f;
  localparam logic [4:0] RF_HI     = 5'h1f;
  localparam logic [3:0] NIB_ZERO  = 4'h0;
  localparam logic [3:0] NIB_FULL  = 4'hf;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  localparam int REG_AW = 3;
  localparam int REG_DW = 16;
  localparam logic [2:0] REG_PROG_ADDR = 3'h0;
  localparam logic [2:0] REG_PROG_DATA = 3'h1;
  localparam logic [2:0] REG_CTRL      = 3'h2;
  localparam logic [2:0] REG_STATUS    = 3'h3;
  localparam logic [2:0] REG_ACC       = 3'h4;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_TA_LSB  = 4;
  localparam int STAT_DEPTH   = 10;
  localparam int STAT_CARRY   = 11;
  localparam int STAT_STATUS  = 12;
  localparam int STAT_STBY    = 13;

endpackage

// ==== irs_core_sequencer.sv ====
// Core sequencer of a 4-bit controller: fetch, branch, call, flags, RAM.
// Assumes inputs synchronous to i_core_clk; program store loaded over the
// register port while the run bit is clear.
//
// Functional notes
// - 10-bit instruction pointer advances by instruction length when not branching.
// - Taken branches load the pointer with the operand target.
// - Subroutine branch saves the address after the call, then loads the target.
// - Return reloads the pointer from the save register; save keeps its value.
// - Reset puts the instruction pointer at 000H.
// - One call-depth bit: reset clear, call increments, return decrements.
// - Depth overflow or underflow forces an internal system reset.
// - 10-bit return save; low byte lives in the last RAM pair.
// - Data access of either word of the last RAM pair spoils the save's upper two bits.
// - Program words are 10 bits; 3EAH to 3FFH is a test area.
// - Fetch or table read in unimplemented or test area restarts at 000H.
// - 32x4 RAM; reset clears table pointer low pair, keeps the rest.
// - Table address is pointer pair plus two control bits; resets to zero.
// - 4-bit accumulator feeds the logic unit; not cleared by reset.
// - Condition test sets status when the selected condition holds, else clears.
// - Standby exit sets status; halt with condition sets it; failing halt clears.
// - Codes 000/011/110 test key inputs; 101 tests timer count zero.
// - Operand bit 3 adds either sense input as a condition.
// - And/xor set carry only when both bit 3 values are one.
// - Rotates load carry with the old accumulator bit 3.
// - Increment and add step set carry when the accumulator was 0FH.
// - Or, transfer and port read clear carry.
module irs_core_sequencer
  import irs_pkg::*;
#(
  parameter int ROM_WORDS = 512,
  parameter int RAM_WORDS = 32
) (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_resetn,
  input  wire logic [irs_pkg::REG_AW-1:0] i_addr,
  input  wire logic [irs_pkg::REG_DW-1:0] i_wr_data,
  input  wire logic                    i_wr_stb,
  input  wire logic                    i_rd_stb,
  input  wire logic [3:0]              i_key_return_inputs,
  input  wire logic                    i_sense_input_zero,
  input  wire logic                    i_sense_or_indicator_pin,
  input  wire logic                    i_timer_zero,
  output logic [irs_pkg::REG_DW-1:0]   o_rd_data,
  output logic [9:0]                   o_instruction_pointer,
  output logic                         o_sys_reset,
  output logic                         o_standby
);
  import irs_pkg::*;

  localparam int AW = $clog2(ROM_WORDS);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ROM_WORDS > 512 || ROM_WORDS < 2 || (1 << AW) != ROM_WORDS) begin : g_bad_rom
    $error("ROM_WORDS must be a power of two up to 512");
  end
  if (RAM_WORDS != 32) begin : g_bad_ram
    $error("RAM_WORDS must be 32: pointer and save pairs are fixed");
  end

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [9:0]        rom [ROM_WORDS];
  logic [3:0]        ram [RAM_WORDS];
  logic [9:0]        ip;
  logic              depth;
  logic              carry;
  logic              status;
  logic [3:0]        acc;
  logic [1:0]        ras_hi;
  logic [1:0]        ta_hi;
  logic              run_en;
  logic [AW-1:0]     prog_addr;
  irs_state_t        state;

  logic [9:0]        next_ip;
  logic              next_depth;
  logic              next_carry;
  logic              next_status;
  logic [3:0]        next_acc;
  irs_state_t        next_state;

  logic [9:0]        word;
  logic [9:0]        arg;
  irs_op_t           opcode;
  logic [5:0]        oper;
  logic              two_word;
  logic [9:0]        ip_seq;
  logic [9:0]        ras;
  logic [9:0]        ta;
  logic              cond;
  logic              keys_hi;
  logic              ram_we;
  logic              call_save;
  logic              ras_clobber;
  logic              depth_err;
  logic              trap;

  // ----------------------------------------
  // Fetch and decode
  // ----------------------------------------
  assign ip_seq   = ip + (two_word ? 10'h002 : 10'h001);
  assign word     = rom[ip[AW-1:0]];
  assign arg      = rom[ip[AW-1:0] + AW'(1)];
  assign opcode   = irs_op_t'(word[OPC_MSB:OPC_LSB]);
  assign oper     = word[5:0];
  assign two_word = (opcode >= OP_JMP) && (opcode <= OP_CALL);
  assign ras      = {ras_hi, ram[RF_HI], ram[RF_LO]};
  assign ta       = {ta_hi, ram[R0_HI], ram[R0_LO]};
  assign keys_hi  = |i_key_return_inputs;

  // Condition test: base code, plus sense inputs when bit 3 is set
  always_comb begin
    case (oper[2:0])
      3'h0, 3'h3, 3'h6: cond = keys_hi;
      3'h5:             cond = i_timer_zero;
      default:          cond = 1'b0;
    endcase
    if (oper[3] && (i_sense_input_zero || i_sense_or_indicator_pin)) begin
      cond = 1'b1;
    end
  end

  // ----------------------------------------
  // Execute
  // ----------------------------------------
  // Everything below reads the flags as they stand before this instruction.
  always_comb begin
    next_ip     = ip;
    next_depth  = depth;
    next_carry  = carry;
    next_status = status;
    next_acc    = acc;
    next_state  = state;
    ram_we      = 1'b0;
    call_save   = 1'b0;
    ras_clobber = 1'b0;
    depth_err   = 1'b0;
    trap        = 1'b0;
    if (run_en) begin
      case (state)
        ST_RUN: begin
          if (ip >= 10'(ROM_WORDS) || ip >= TEST_BASE) begin
            trap = 1'b1;
          end else begin
            next_ip = ip_seq;
            case (opcode)
              OP_MISC: begin
                if (oper[5]) begin
                  ram_we      = 1'b1;
                  ras_clobber = (oper[4:0] == RF_LO) || (oper[4:0] == RF_HI);
                end else if (oper[4]) begin
                  if (ta >= 10'(ROM_WORDS) || ta >= TEST_BASE) begin
                    trap = 1'b1;
                  end else begin
                    next_acc = rom[ta[AW-1:0]][3:0];
                  end
                end
              end
              OP_JMP: next_ip = arg;
              OP_JC: begin
                if (carry) next_ip = arg;
              end
              OP_JNC: begin
                if (!carry) next_ip = arg;
              end
              OP_JF: begin
                if (status) next_ip = arg;
              end
              OP_JNF: begin
                if (!status) next_ip = arg;
              end
              OP_CALL: begin
                if (depth) begin
                  depth_err = 1'b1;
                end else begin
                  call_save  = 1'b1;
                  next_depth = 1'b1;
                  next_ip    = arg;
                end
              end
              OP_RET: begin
                if (!depth) begin
                  depth_err = 1'b1;
                end else begin
                  next_depth = 1'b0;
                  next_ip    = ras;
                end
              end
              OP_ANL: begin
                next_acc   = acc & oper[3:0];
                next_carry = acc[3] & oper[3];
              end
              OP_XRL: begin
                next_acc   = acc ^ oper[3:0];
                next_carry = acc[3] & oper[3];
              end
              OP_ORL: begin
                next_acc   = acc | oper[3:0];
                next_carry = 1'b0;
              end
              OP_ROT: begin
                next_acc   = {acc[2:0], oper[0] ? 1'b0 : acc[3]};
                next_carry = acc[3];
              end
              OP_INC: begin
                // Bit 0 set is the add step: only the carry moves
                if (!oper[0]) next_acc = acc + 4'h1;
                next_carry = (acc == NIB_FULL);
              end
              OP_MOV: begin
                if (oper[5]) begin
                  next_acc    = ram[oper[4:0]];
                  ras_clobber = (oper[4:0] == RF_LO) || (oper[4:0] == RF_HI);
                end else if (oper[4]) begin
                  next_acc = i_key_return_inputs;
                end else begin
                  next_acc = oper[3:0];
                end
                next_carry = 1'b0;
              end
              OP_CONDITION_TEST_INSTRUCTION: next_status = cond;
              OP_HALT: begin
                if (keys_hi) begin
                  next_status = 1'b1;
                end else if (status) begin
                  next_status = 1'b0;
                end else begin
                  next_state = ST_STANDBY;
                end
              end
              default: next_ip = ip_seq;
            endcase
          end
        end
        ST_STANDBY: begin
          if (keys_hi) begin
            next_status = 1'b1;
            next_state  = ST_RUN;
          end
        end
        default: next_state = ST_RUN;
      endcase
    end
    if (trap) begin
      next_ip = RESET_IP;
    end
    if (depth_err) begin
      next_ip    = RESET_IP;
      next_depth = 1'b0;
    end
  end

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ip    <= RESET_IP;
      depth <= 1'b0;
      state <= ST_RUN;
    end else begin
      ip    <= next_ip;
      depth <= next_depth;
      state <= next_state;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      carry  <= 1'b0;
      status <= 1'b0;
    end else begin
      carry  <= next_carry;
      status <= next_status;
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_sys_reset <= 1'b0;
    end else begin
      o_sys_reset <= depth_err;
    end
  end

  // Accumulator keeps whatever it held across reset
  always_ff @(posedge i_core_clk) begin
    acc <= next_acc;
  end

  // ----------------------------------------
  // Data RAM and return save
  // ----------------------------------------
  // No reset on the array: only the pointer pair is cleared, by a clocked
  // write while reset is held, so the other words survive.
  always_ff @(posedge i_core_clk) begin
    if (!rst_n || depth_err) begin
      ram[R0_LO] <= NIB_ZERO;
      ram[R0_HI] <= NIB_ZERO;
    end else if (call_save) begin
      ram[RF_LO] <= ip_seq[3:0];
      ram[RF_HI] <= ip_seq[7:4];
    end else if (ram_we) begin
      ram[oper[4:0]] <= acc;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (call_save) begin
      ras_hi <= ip_seq[9:8];
    end else if (ras_clobber) begin
      ras_hi <= 2'h0;
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_en    <= 1'b0;
      ta_hi     <= 2'h0;
      prog_addr <= '0;
    end else begin
      if (depth_err) begin
        ta_hi <= 2'h0;
      end
      if (i_wr_stb) begin
        if (i_addr == REG_PROG_ADDR) begin
          prog_addr <= i_wr_data[AW-1:0];
        end else if (i_addr == REG_PROG_DATA) begin
          prog_addr <= prog_addr + AW'(1);
        end else if (i_addr == REG_CTRL) begin
          run_en <= i_wr_data[CTRL_RUN_BIT];
          ta_hi  <= i_wr_data[CTRL_TA_LSB+1:CTRL_TA_LSB];
        end
      end
    end
  end

  // Program store: loading while running is allowed but races fetch
  always_ff @(posedge i_core_clk) begin
    if (i_wr_stb && i_addr == REG_PROG_DATA) begin
      rom[prog_addr] <= i_wr_data[9:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rd_data <= '0;
    end else if (!i_rd_stb) begin
      o_rd_data <= '0;
    end else if (i_addr == REG_PROG_ADDR) begin
      o_rd_data <= REG_DW'(prog_addr);
    end else if (i_addr == REG_CTRL) begin
      o_rd_data <= REG_DW'({ta_hi, 3'h0, run_en});
    end else if (i_addr == REG_STATUS) begin
      o_rd_data <= {2'h0, state == ST_STANDBY, status, carry, depth, ip};
    end else if (i_addr == REG_ACC) begin
      o_rd_data <= {2'h0, ras, acc};
    end else begin
      o_rd_data <= '0;
    end
  end

  assign o_instruction_pointer = ip;
  assign o_standby             = (state == ST_STANDBY);

endmodule

// ==== irs_core_sequencer_asserts.sv ====
// Port-level checks of the core sequencer.
// Assumes it is bound to irs_core_sequencer and sees only its ports.
module irs_core_sequencer_asserts
  import irs_pkg::*;
#(
  parameter int ROM_WORDS = 512,
  parameter int RAM_WORDS = 32
) (
  input wire logic                          i_core_clk,
  input wire logic                          i_resetn,
  input wire logic [irs_pkg::REG_AW-1:0]    i_addr,
  input wire logic [irs_pkg::REG_DW-1:0]    i_wr_data,
  input wire logic                          i_wr_stb,
  input wire logic                          i_rd_stb,
  input wire logic [3:0]                    i_key_return_inputs,
  input wire logic                          i_sense_input_zero,
  input wire logic                          i_sense_or_indicator_pin,
  input wire logic                          i_timer_zero,
  input wire logic [irs_pkg::REG_DW-1:0]    o_rd_data,
  input wire logic [9:0]                    o_instruction_pointer,
  input wire logic                          o_sys_reset,
  input wire logic                          o_standby
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  ip_reset_zero_a: assert property ($rose(i_resetn) |-> (o_instruction_pointer == 10'h000) [*3])
    else $error("pointer left zero too early after reset");
  quiet_after_reset_a: assert property ($rose(i_resetn) |-> !o_standby && !o_sys_reset)
    else $error("standby or system reset high after reset");
  trap_restart_a: assert property (o_instruction_pointer >= 10'(ROM_WORDS) |=> o_instruction_pointer == 10'h000)
    else $error("fetch outside program store did not restart");
  sysrst_pulse_a: assert property (o_sys_reset |=> !o_sys_reset)
    else $error("system reset longer than one cycle");
  sysrst_ip_zero_a: assert property ($rose(o_sys_reset) |->
      o_instruction_pointer == 10'h000)
    else $error("system reset without pointer at zero");
  rd_idle_zero_a: assert property (!i_rd_stb |=> o_rd_data == 16'h0000)
    else $error("read data outside its cycle");
  rd_ip_track_a: assert property (i_rd_stb && i_addr == REG_STATUS |=>
      o_rd_data[9:0] == $past(o_instruction_pointer))
    else $error("status read disagrees with pointer");
  rd_stby_track_a: assert property (i_rd_stb && i_addr == REG_STATUS |=>
      o_rd_data[STAT_STBY] == $past(o_standby))
    else $error("status read disagrees with standby");
  stby_hold_a: assert property (o_standby && i_key_return_inputs == 4'h0 |=>
      o_standby && $stable(o_instruction_pointer))
    else $error("standby left without a key");
  stby_wake_a: assert property (o_standby && i_key_return_inputs != 4'h0 |=> !o_standby)
    else $error("key did not end standby");
endmodule

// ==== irs_prog_image.sv ====
// Program image standing for the on-chip program store contents.
// Assumes the bench writes img directly and copies it in over the register port.
module irs_prog_image;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Image
  // ----------------------------------------
  logic [9:0] img [0:511];

  // Whole-store fill, so words left over from an earlier program never leak in
  task automatic fill(input logic [9:0] v);
    foreach (img[k]) begin
      img[k] = v;
    end
  endtask
endmodule

// ==== tb_ir_remote_mcu_core_sequencer.sv ====
// Bench for the core sequencer: loads programs, runs them, reads state back.
// Assumes the checker and the program image model are compiled before it.
module tb_ir_remote_mcu_core_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import irs_pkg::*;
  // ----------------------------------------
  // Signals, design and helpers
  // ----------------------------------------
  logic        i_core_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic [2:0]  i_addr = 3'h0;
  logic [15:0] i_wr_data;
  logic        i_wr_stb = 1'b0;
  logic        i_rd_stb = 1'b0;
  logic [3:0]  i_key_return_inputs;
  logic        i_sense_input_zero;
  logic        i_sense_or_indicator_pin;
  logic        i_timer_zero;
  logic [15:0] o_rd_data;
  logic [9:0]  o_instruction_pointer;
  logic        o_sys_reset;
  logic        o_standby;
  int          err_total = 0;
  int          cmp_count = 0;
  int          pulses = 0;
  logic [15:0] rd;
  logic [3:0]  ops [0:5] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd};
  logic [2:0]  codes [0:3] = '{3'h0, 3'h3, 3'h6, 3'h5};
  logic [9:0]  traps [0:2] = '{10'h3ea, 10'h3ff, 10'h200};

  `define CHECK_EQ(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
    $display("FAIL t=%0t got %0h expected %0h", $time, got, exp); end end

  always #4 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (o_sys_reset === 1'b1) pulses++;

  irs_core_sequencer DUT (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
    .i_key_return_inputs(i_key_return_inputs), .i_sense_input_zero(i_sense_input_zero),
    .i_sense_or_indicator_pin(i_sense_or_indicator_pin), .i_timer_zero(i_timer_zero),
    .o_rd_data(o_rd_data), .o_instruction_pointer(o_instruction_pointer),
    .o_sys_reset(o_sys_reset), .o_standby(o_standby));
  irs_prog_image P ();

  // One logic-unit step; kin is the key level that a port read would take
  function automatic void alu(input logic [9:0] w, input logic [3:0] kin, inout logic [3:0] a,
                              inout logic c, inout logic ak, inout logic ck);
    case (w[9:6])
      4'h8, 4'h9: c = a[3] & w[3];
      4'hb: c = a[3];
      4'hc: c = (a == 4'hf);
      default: c = 1'b0;
    endcase
    case (w[9:6])
      4'h8: a = a & w[3:0];
      4'h9: a = a ^ w[3:0];
      4'ha: a = a | w[3:0];
      4'hb: a = {a[2:0], w[0] ? 1'b0 : a[3]};
      4'hc: a = w[0] ? a : a + 4'h1;
      default: a = w[4] ? kin : w[3:0];
    endcase
    ck = ak || (w[9:6] inside {4'ha, 4'hd});
    ak = ak || (w[9:6] == 4'hd);
  endfunction

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_stb <= 1'b1;
  endtask

  task automatic rdr(input logic [2:0] a);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wr_stb <= 1'b0;
    i_rd_stb <= 1'b1;
    @(posedge i_core_clk);
    i_rd_stb <= 1'b0;
    #1 rd = o_rd_data;
  endtask

  task automatic do_reset();
    @(posedge i_core_clk);
    i_resetn <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_core_clk);
  endtask

  task automatic run_prog(input int n, input logic [1:0] tbits);
    do_reset();
    pulses = 0;
    wr(REG_PROG_ADDR, 16'h0);
    for (int k = 0; k < n; k++) begin
      wr(REG_PROG_DATA, {6'h0, P.img[k]});
    end
    wr(REG_CTRL, {10'h0, tbits, 4'h1});
    @(posedge i_core_clk);
    i_wr_stb <= 1'b0;
    repeat (40) @(posedge i_core_clk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [3:0] a, lo, hi, kv;
    logic       c, ck, ak, st, tk;
    logic [4:0] tv;
    logic [9:0] w, ipa;
    int         k, op;
    void'($urandom(62624));
    {i_wr_data, i_sense_input_zero, i_sense_or_indicator_pin, i_timer_zero} <= 19'($urandom);
    repeat (40) begin
      P.fill(10'h000);
      a = 4'($urandom);
      k = $urandom_range(1, 6);
      kv = 4'($urandom);
      i_key_return_inputs <= kv;
      P.img[0] = {4'hd, 2'b00, a};
      {ak, ck, c} = 3'b110;
      for (int j = 1; j <= k; j++) begin
        w = {ops[$urandom_range(0, 5)], 1'b0, 1'($urandom), 4'($urandom)};
        P.img[j] = w;
        alu(w, kv, a, c, ak, ck);
      end
      P.img[k + 1] = 10'h040;
      P.img[k + 2] = 10'(k + 1);
      run_prog(k + 3, 2'b00);
      `CHECK_EQ(o_instruction_pointer, 10'(k + 1))
      rdr(REG_STATUS);
      if (ck) `CHECK_EQ(rd[STAT_CARRY], c)
      rdr(REG_ACC);
      if (ak) `CHECK_EQ(rd[3:0], a)
    end
    for (int i = 0; i < 40; i++) begin
      P.fill(10'h000);
      a = ($urandom_range(0, 1) != 0) ? 4'hf : 4'($urandom);
      lo = {1'($urandom), codes[$urandom_range(0, 3)]};
      op = 1 + i % 5;
      {i_key_return_inputs, i_sense_input_zero, i_sense_or_indicator_pin, i_timer_zero} <=
        7'($urandom & $urandom);
      P.img[0] = {4'hd, 2'b00, a};
      P.img[1] = 10'h300;
      P.img[2] = {4'he, 2'b00, lo};
      P.img[3] = {4'(op), 6'h00};
      P.img[4] = 10'h008;
      P.img[5] = 10'h040;
      P.img[6] = 10'h005;
      P.img[8] = 10'h040;
      P.img[9] = 10'h008;
      run_prog(10, 2'b00);
      c = (a == 4'hf);
      st = ((lo[2:0] inside {3'h0, 3'h3, 3'h6}) && (|i_key_return_inputs)) ||
           (lo[2:0] == 3'h5 && i_timer_zero) ||
           (lo[3] && (i_sense_input_zero || i_sense_or_indicator_pin));
      tv = {!st, st, !c, c, 1'b1};
      `CHECK_EQ(o_instruction_pointer, tv[op - 1] ? 10'h008 : 10'h005)
      rdr(REG_STATUS);
      `CHECK_EQ(rd[STAT_STATUS], st)
      `CHECK_EQ(rd[STAT_CARRY], c)
    end
    repeat (16) begin
      P.fill(10'h000);
      i_key_return_inputs <= ($urandom_range(0, 1) != 0) ? 4'h0 : 4'($urandom);
      {i_sense_input_zero, i_sense_or_indicator_pin, i_timer_zero} <= 3'($urandom & $urandom);
      P.img[0] = 10'h38d;
      P.img[1] = 10'h3c0;
      P.img[2] = 10'h040;
      P.img[3] = 10'h002;
      run_prog(4, 2'b00);
      st = i_timer_zero || i_sense_input_zero || i_sense_or_indicator_pin;
      tk = !(|i_key_return_inputs) && !st;
      `CHECK_EQ(o_standby, tk)
      if (tk) begin
        @(posedge i_core_clk);
        i_key_return_inputs <= 4'h4;
        repeat (4) @(posedge i_core_clk);
        #1;
      end
      `CHECK_EQ(o_instruction_pointer, 10'h002)
      rdr(REG_STATUS);
      `CHECK_EQ(rd[STAT_STATUS], (|i_key_return_inputs) || !st)
    end
    P.fill(10'h000);
    P.img[0] = 10'h180;
    P.img[1] = 10'h005;
    P.img[2] = 10'h040;
    P.img[3] = 10'h002;
    P.img[5] = 10'h1c0;
    run_prog(6, 2'b00);
    `CHECK_EQ(o_instruction_pointer, 10'h002)
    rdr(REG_STATUS);
    `CHECK_EQ(rd[STAT_DEPTH], 1'b0)
    `CHECK_EQ(pulses, 0)
    do_reset();
    rdr(REG_ACC);
    `CHECK_EQ(rd[13:4], 10'h002)
    P.img[5] = 10'h180;
    P.img[6] = 10'h005;
    run_prog(7, 2'b00);
    `CHECK_EQ(pulses > 0, 1'b1)
    P.fill(10'h000);
    P.img[1] = 10'h1c0;
    run_prog(2, 2'b00);
    `CHECK_EQ(pulses > 0, 1'b1)
    foreach (traps[t]) begin
      P.fill(10'h000);
      P.img[0] = 10'h040;
      P.img[1] = traps[t];
      run_prog(2, 2'b00);
      ipa = o_instruction_pointer;
      @(posedge i_core_clk);
      #1 `CHECK_EQ(ipa ^ o_instruction_pointer, traps[t])
    end
    repeat (6) begin
      P.fill(10'h000);
      lo = 4'($urandom);
      hi = 4'($urandom);
      w = 10'($urandom);
      P.img[0] = {4'hd, 2'b00, lo};
      P.img[1] = 10'h020;
      P.img[2] = {4'hd, 2'b00, hi};
      P.img[3] = 10'h030;
      P.img[4] = 10'h010;
      P.img[5] = 10'h040;
      P.img[6] = 10'h005;
      P.img[{2'b01, hi, lo}] = w;
      run_prog(512, 2'b01);
      rdr(REG_ACC);
      `CHECK_EQ(rd[3:0], w[3:0])
    end
    P.fill(10'h00f);
    P.img[0] = 10'h010;
    P.img[1] = 10'h040;
    P.img[2] = 10'h001;
    run_prog(512, 2'b00);
    rdr(REG_ACC);
    `CHECK_EQ(rd[3:0], 4'h0)
    report_and_stop();
  end
endmodule

bind irs_core_sequencer irs_core_sequencer_asserts #(.ROM_WORDS(ROM_WORDS),
  .RAM_WORDS(RAM_WORDS)) CHK_I (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
  .i_key_return_inputs(i_key_return_inputs), .i_sense_input_zero(i_sense_input_zero),
  .i_sense_or_indicator_pin(i_sense_or_indicator_pin), .i_timer_zero(i_timer_zero),
  .o_rd_data(o_rd_data), .o_instruction_pointer(o_instruction_pointer),
  .o_sys_reset(o_sys_reset), .o_standby(o_standby));
